// ---- rtl/sfpe_pkg.sv ----
// sfpe_pkg: opcodes, address layout, timing counts and types
// assumes a 50 MHz core clock and a 24-bit address after every opcode
package sfpe_pkg;

	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_LOAD1 = 8'h84;
	localparam logic [7:0] OP_LOAD2 = 8'h87;
	localparam logic [7:0] OP_EP1 = 8'h83;
	localparam logic [7:0] OP_EP2 = 8'h86;
	localparam logic [7:0] OP_P1 = 8'h88;
	localparam logic [7:0] OP_P2 = 8'h89;
	localparam logic [7:0] OP_PE = 8'h81;
	localparam logic [7:0] OP_BE = 8'h50;

	// ----------------------------------------
	// layout
	// ----------------------------------------
	localparam int BUF_DEPTH = 528;
	localparam int PAGE_W = 12;
	localparam int POS_W = 10;
	localparam int BLK_LOW = 3;
	localparam logic [9:0] LAST_528 = 10'h20F;
	localparam logic [9:0] LAST_512 = 10'h1FF;
	localparam logic [2:0] BYTE_DATA = 3'h4;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int ST_RDY_BIT = 7;
	localparam int ST_MODE_BIT = 0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int EP_TIME_US = 40000;
	localparam int P_TIME_US = 6000;
	localparam int PE_TIME_US = 35000;
	localparam int BE_TIME_US = 100000;
	localparam int EP_CYC = EP_TIME_US * CLK_MHZ;
	localparam int P_CYC = P_TIME_US * CLK_MHZ;
	localparam int PE_CYC = PE_TIME_US * CLK_MHZ;
	localparam int BE_CYC = BE_TIME_US * CLK_MHZ;
	localparam int TMR_W = 24;

	typedef enum logic [1:0] {SF_IDLE, SF_CHAIN, SF_WAIT} sfpe_state_type;

	// page number from a 24-bit address
	function automatic logic [11:0] page_of(input logic [23:0] a, input logic m512);
		page_of = m512 ? a[20:9] : a[21:10];
	endfunction : page_of

	// starting buffer position from a 24-bit address
	function automatic logic [9:0] pos_of(input logic [23:0] a, input logic m512);
		pos_of = m512 ? {1'b0, a[8:0]} : a[9:0];
	endfunction : pos_of

	function automatic logic [9:0] last_pos(input logic m512);
		last_pos = m512 ? LAST_512 : LAST_528;
	endfunction : last_pos

endpackage : sfpe_pkg

// ---- rtl/sfpe_top.sv ----
// sfpe_top: serial flash program/erase command sequencer with two page buffers
// assumes SPI mode 0 on link_sck, which only toggles while cs_n is low
`timescale 1ns/10ps
module sfpe_top
	import sfpe_pkg::*;
#(
	parameter int EP_CYCLES = EP_CYC,
	parameter int P_CYCLES = P_CYC,
	parameter int PE_CYCLES = PE_CYC,
	parameter int BE_CYCLES = BE_CYC
) (
	// core clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// serial link
	input wire logic link_sck,
	input wire logic cs_n,
	input wire logic si,
	// configuration
	input wire logic page_512,
	// flash array side
	output logic arr_erase,
	output logic arr_prog,
	output logic [11:0] arr_page,
	output logic arr_block,
	output logic arr_buf,
	input wire logic [9:0] arr_rd_addr,
	output logic [7:0] arr_rd_data,
	// status
	output logic [7:0] status,
	output logic ready_pin
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	localparam int TMR_MAX = 2 ** TMR_W;
	if (EP_CYCLES < 2 || P_CYCLES < 1 || PE_CYCLES < 1 || BE_CYCLES < 1 ||
		EP_CYCLES >= TMR_MAX || P_CYCLES >= TMR_MAX || PE_CYCLES >= TMR_MAX ||
		BE_CYCLES >= TMR_MAX) begin : g_chk
		$error("sfpe_top: operation cycle counts out of range");
	end

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef struct packed {
		logic m1;
		logic m2;
		logic [2:0] bitcnt;
		logic [6:0] sh;
		logic [2:0] bytes;
		logic [9:0] pos;
	} sfpe_link_type;

	typedef struct packed {
		logic [7:0] op;
		logic [23:0] addr;
		logic [2:0] nb;
	} sfpe_cap_type;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic m1;
		logic m2;
		sfpe_state_type state;
		logic [TMR_W-1:0] tmr;
		logic busy;
		logic erase;
		logic prog;
		logic [11:0] page;
		logic blk;
		logic bufsel;
		logic [7:0] rd;
	} sfpe_core_type;

	sfpe_link_type lk_q, lk_d;
	sfpe_cap_type cap_q, cap_d;
	sfpe_core_type co_q, co_d;
	logic [7:0] bufmem [2][BUF_DEPTH];
	logic wr_en;
	logic wr_buf;
	logic [9:0] wr_pos;
	logic [7:0] wr_data;

	// ----------------------------------------
	// link domain: byte assembly and buffer load
	// ----------------------------------------
	always_comb begin
		logic [7:0] b;
		logic [23:0] na;
		b = {lk_q.sh, si};
		na = {cap_q.addr[15:0], b};
		lk_d = lk_q;
		cap_d = cap_q;
		wr_en = 1'b0;
		wr_buf = (cap_q.op == OP_LOAD2);
		wr_pos = lk_q.pos;
		wr_data = b;
		lk_d.m1 = co_q.m2;
		lk_d.m2 = lk_q.m1;
		lk_d.bitcnt = lk_q.bitcnt + 3'h1;
		lk_d.sh = {lk_q.sh[5:0], si};
		if (lk_q.bitcnt == 3'h0 && lk_q.bytes == 3'h0) begin
			cap_d.nb = 3'h0;
		end
		if (lk_q.bitcnt == BIT_LAST) begin
			if (lk_q.bytes == 3'h0) begin
				cap_d.op = b;
			end else if (lk_q.bytes < BYTE_DATA) begin
				cap_d.addr = na;
				// start position parsed for the configured page size
				if (lk_q.bytes == 3'h3) begin
					lk_d.pos = pos_of(na, lk_q.m2);
				end
			end else if (cap_q.op == OP_LOAD1 || cap_q.op == OP_LOAD2) begin
				wr_en = 1'b1;
				lk_d.pos = (lk_q.pos == last_pos(lk_q.m2)) ? 10'h000 :
					lk_q.pos + 10'h001;
			end
			if (lk_q.bytes != BYTE_DATA) begin
				lk_d.bytes = lk_q.bytes + 3'h1;
				cap_d.nb = lk_q.bytes + 3'h1;
			end
		end
	end

	// frame counters clear while the chip is deselected
	always_ff @(posedge link_sck or posedge cs_n) begin
		if (cs_n) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// captured command holds after the frame for the core to read
	always_ff @(posedge link_sck) begin
		cap_q <= cap_d;
	end

	always_ff @(posedge link_sck) begin
		if (wr_en) begin
			bufmem[wr_buf][wr_pos] <= wr_data;
		end
	end

	// ----------------------------------------
	// core domain: command start and timing
	// ----------------------------------------
	always_comb begin
		logic [11:0] pg;
		logic rise;
		pg = page_of(cap_q.addr, co_q.m2);
		rise = co_q.s3 & ~co_q.s2;
		co_d = co_q;
		co_d.s1 = ~cs_n;
		co_d.s2 = co_q.s1;
		co_d.s3 = co_q.s2;
		co_d.m1 = page_512;
		co_d.m2 = co_q.m1;
		co_d.erase = 1'b0;
		co_d.prog = 1'b0;
		co_d.rd = (arr_rd_addr < 10'(BUF_DEPTH)) ? bufmem[co_q.bufsel][arr_rd_addr] : 8'h00;
		case (co_q.state)
			SF_IDLE: begin
				if (rise && cap_q.nb == BYTE_DATA) begin
					co_d.page = pg;
					co_d.blk = 1'b0;
					case (cap_q.op)
						OP_EP1, OP_EP2: begin
							co_d.bufsel = (cap_q.op == OP_EP2);
							co_d.erase = 1'b1;
							co_d.state = SF_CHAIN;
							co_d.tmr = TMR_W'(EP_CYCLES - 1);
						end
						OP_P1, OP_P2: begin
							co_d.bufsel = (cap_q.op == OP_P2);
							co_d.prog = 1'b1;
							co_d.state = SF_WAIT;
							co_d.tmr = TMR_W'(P_CYCLES - 1);
						end
						OP_PE: begin
							co_d.erase = 1'b1;
							co_d.state = SF_WAIT;
							co_d.tmr = TMR_W'(PE_CYCLES - 1);
						end
						OP_BE: begin
							// low page bits ignored for a block
							co_d.page = {pg[11:BLK_LOW], 3'h0};
							co_d.blk = 1'b1;
							co_d.erase = 1'b1;
							co_d.state = SF_WAIT;
							co_d.tmr = TMR_W'(BE_CYCLES - 1);
						end
						default: begin
						end
					endcase
				end
			end
			SF_CHAIN: begin
				co_d.prog = 1'b1;
				co_d.state = SF_WAIT;
				co_d.tmr = co_q.tmr - TMR_W'(1);
			end
			SF_WAIT: begin
				if (co_q.tmr == '0) begin
					co_d.state = SF_IDLE;
				end else begin
					co_d.tmr = co_q.tmr - TMR_W'(1);
				end
			end
			default: begin
				co_d.state = SF_IDLE;
			end
		endcase
		co_d.busy = (co_d.state != SF_IDLE);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			co_q <= '0;
		end else begin
			co_q <= co_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign arr_erase = co_q.erase;
	assign arr_prog = co_q.prog;
	assign arr_page = co_q.page;
	assign arr_block = co_q.blk;
	assign arr_buf = co_q.bufsel;
	assign arr_rd_data = co_q.rd;
	assign ready_pin = ~co_q.busy;
	assign status = {~co_q.busy, 6'h00, co_q.m2};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// two clock domains here, so every check names its own clock
	logic cs_rise;
	assign cs_rise = co_q.s3 & ~co_q.s2;

	busy_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
		ready_pin == (co_q.state == SF_IDLE) && status[ST_RDY_BIT] == ready_pin)
		else $error("ready pin and status disagree with busy");
	erase_then_prog_a: assert property (@(posedge core_clk) disable iff (!rstn)
		co_q.erase && co_q.state == SF_CHAIN |=> co_q.prog && co_q.busy)
		else $error("program did not follow built-in erase");
	plain_prog_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(co_q.busy) && co_q.prog |-> !co_q.erase && !$past(co_q.erase))
		else $error("plain program erased the page");
	block_align_a: assert property (@(posedge core_clk) disable iff (!rstn)
		co_q.erase && co_q.blk |-> co_q.page[2:0] == 3'h0)
		else $error("block erase page not aligned to eight");
	start_on_rise_a: assert property (@(posedge core_clk) disable iff (!rstn)
		cs_rise && !co_q.busy && cap_q.nb == BYTE_DATA &&
		(cap_q.op == OP_PE || cap_q.op == OP_BE) |=> co_q.erase && co_q.busy)
		else $error("erase did not start on select rise");
	page_parse_a: assert property (@(posedge core_clk) disable iff (!rstn)
		cs_rise && !co_q.busy && cap_q.nb == BYTE_DATA &&
		cap_q.op == OP_PE |=> arr_page == (co_q.m2 ? $past(cap_q.addr[20:9]) :
		$past(cap_q.addr[21:10])))
		else $error("page number parsed wrongly");
	timer_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
		co_q.state == SF_WAIT && co_q.tmr != '0 |=>
		co_q.busy && co_q.tmr == $past(co_q.tmr) - TMR_W'(1))
		else $error("operation timer did not count down");
	busy_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		co_q.state == SF_WAIT && co_q.tmr == '0 |=> !co_q.busy && ready_pin)
		else $error("busy did not clear at end of operation");
	no_pulse_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!co_q.busy |-> !arr_erase && !arr_prog)
		else $error("array strobe while not busy");
	buf_wrap_a: assert property (@(posedge link_sck) disable iff (cs_n)
		wr_en && lk_q.pos == last_pos(lk_q.m2) |=> lk_q.pos == 10'h000)
		else $error("buffer position did not wrap");

	ep_cover_c: cover property (@(posedge core_clk) co_q.erase ##1 co_q.prog);
	be_cover_c: cover property (@(posedge core_clk) co_q.erase && co_q.blk);
	wrap_cover_c: cover property (@(posedge link_sck) wr_en && lk_q.pos == LAST_512);

endmodule : sfpe_top

// ---- verif/sfpe_host.sv ----
// sfpe_host: serial host model driving command frames
// assumes the caller spaces frames; the link clock only runs inside a frame
`timescale 1ns/10ps
module sfpe_host (
	// serial link
	output logic link_sck,
	output logic cs_n,
	output logic si
);
	initial begin
		link_sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// -------------------------------
	// one frame, msb first, mode 0
	// -------------------------------
	// frame is left aligned in fr; nb bytes of it are sent
	task automatic send(input logic [63:0] fr, input int nb);
		#3;
		cs_n = 1'b0;
		for (int i = 0; i < nb * 8; i++) begin
			si = fr[63 - i];
			#6 link_sck = 1'b1;
			#6 link_sck = 1'b0;
		end
		#6 cs_n = 1'b1;
		si = ~si;
	endtask : send
endmodule : sfpe_host

// ---- verif/sfpe_tb_top.sv ----
// sfpe_tb_top: self-checking bench for the program/erase sequencer
// assumes sfpe_host on the link and shortened operation counts
`timescale 1ns/10ps
module sfpe_tb_top import sfpe_pkg::*;;
	localparam int N_EP = 4;
	localparam int N_P = 3;
	localparam int N_PE = 5;
	localparam int N_BE = 6;
	logic core_clk, rstn, page_512, link_sck, cs_n, si;
	logic arr_erase, arr_prog, arr_block, arr_buf, ready_pin;
	logic [11:0] arr_page;
	logic [9:0] arr_rd_addr;
	logic [7:0] arr_rd_data, status;
	logic [15:0] seed;
	logic [7:0] mem [2][528];
	int wr[$];
	int mismatches, check_count;

	sfpe_top #(.EP_CYCLES(N_EP), .P_CYCLES(N_P), .PE_CYCLES(N_PE), .BE_CYCLES(N_BE)) dut_u (
		.core_clk(core_clk), .rstn(rstn), .link_sck(link_sck), .cs_n(cs_n), .si(si),
		.page_512(page_512), .arr_erase(arr_erase), .arr_prog(arr_prog),
		.arr_page(arr_page), .arr_block(arr_block), .arr_buf(arr_buf),
		.arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data), .status(status),
		.ready_pin(ready_pin));
	sfpe_host host_u (.link_sck(link_sck), .cs_n(cs_n), .si(si));

	always #10 core_clk = ~core_clk;

	// -------------------------------
	// helpers
	// -------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [23:0] nx();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return {seed, seed[11:4]};
	endfunction : nx

	task automatic load(input int b, input logic [23:0] a);
		logic [23:0] d;
		int p;
		logic [23:0] r;
		p = page_512 ? (a & 24'h1FF) : (a & 24'h3FF);
		wr = {};
		d = 24'h00_0000;
		for (int i = 0; i < 3; i++) begin
			r = nx();
			d = {d[15:0], r[7:0]};
			mem[b][p] = r[7:0];
			wr.push_back(p);
			p = (p == (page_512 ? 511 : 527)) ? 0 : p + 1;
		end
		host_u.send({b ? 8'h87 : 8'h84, a, d, 8'h00}, 7);
		repeat (6) @(negedge core_clk);
	endtask : load

	task automatic op(input logic [7:0] c, input logic [23:0] a);
		logic [11:0] pg;
		int n, w;
		logic ep, pr;
		pg = 12'((a >> (page_512 ? 9 : 10)) & 24'hFFF);
		if (c == 8'h50) pg[2:0] = 3'h0;
		ep = (c == 8'h83 || c == 8'h86);
		pr = (c == 8'h88 || c == 8'h89);
		n = ep ? N_EP : pr ? N_P : (c == 8'h81) ? N_PE : N_BE;
		host_u.send({c, a, 32'h0000_0000}, 4);
		w = 0;
		while (arr_erase !== 1'b1 && arr_prog !== 1'b1 && w < 12) begin
			@(negedge core_clk);
			w++;
		end
		check(arr_erase, !pr);
		check(arr_prog, pr);
		check(arr_page, pg);
		check(arr_block, c == 8'h50);
		if (ep || pr) check(arr_buf, c == 8'h86 || c == 8'h89);
		check(status, {1'b0, 6'h00, page_512});
		w = 0;
		while (ready_pin === 1'b0 && w < 50) begin
			w++;
			@(negedge core_clk);
			if (w == 1) check(arr_prog, ep);
		end
		check(w, n);
		check(status, {1'b1, 6'h00, page_512});
	endtask : op

	task automatic rd_back(input int b);
		foreach (wr[k]) begin
			arr_rd_addr = 10'(wr[k]);
			@(negedge core_clk);
			check(arr_rd_data, mem[b][wr[k]]);
		end
	endtask : rd_back

	// a frame that must start no operation
	task automatic no_start(input logic [63:0] fr, input int nb);
		host_u.send(fr, nb);
		repeat (8) begin
			@(negedge core_clk);
			check(arr_erase | arr_prog, 1'b0);
			check(ready_pin, 1'b1);
		end
	endtask : no_start

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// -------------------------------
	// sequence
	// -------------------------------
	initial begin
		logic [23:0] a;
		core_clk = 1'b0;
		rstn = 1'b0;
		page_512 = 1'b0;
		arr_rd_addr = 10'h000;
		seed = 16'h9B4C;
		repeat (16) @(negedge core_clk);
		rstn = 1'b1;
		repeat (3) @(negedge core_clk);
		check(ready_pin, 1'b1);
		for (int m = 0; m < 2; m++) begin
			page_512 = m[0];
			repeat (4) @(negedge core_clk);
			for (int b = 0; b < 2; b++) begin
				load(b, m ? 24'hFFFFFE : 24'hFFFE0E);
				a = nx();
				op(8'h81, a);
				op(b ? 8'h89 : 8'h88, a);
				rd_back(b);
				a = nx();
				op(b ? 8'h86 : 8'h83, a);
				rd_back(b);
			end
			a = nx();
			op(8'h50, a);
			// a cut address and an unknown opcode start nothing
			no_start({8'h81, a[23:8], 40'h00_0000_0000}, 3);
			no_start({8'h5A, a, 32'h0000_0000}, 4);
		end
		close_out();
	end

	initial begin
		#200000;
		mismatches++;
		close_out();
	end
endmodule : sfpe_tb_top
